// *** rtl/uemr_pkg.sv ***
// Package: constants and types for the endpoint mode responder
package uemr_pkg;
    localparam logic [11:0] REG_MODE0   = 12'h000;
    localparam logic [11:0] REG_COUNT0  = 12'h004;
    localparam logic [11:0] REG_MODE1   = 12'h008;
    localparam logic [11:0] REG_COUNT1  = 12'h00C;
    localparam logic [11:0] REG_MODE2   = 12'h010;
    localparam logic [11:0] REG_COUNT2  = 12'h014;
    localparam logic [11:0] REG_STATUS  = 12'h018;
    localparam int          STALL_BIT   = 7;
    localparam int          TOK_SETUP_BIT = 7;
    localparam int          TOK_IN_BIT    = 6;
    localparam int          TOK_OUT_BIT   = 5;
    localparam logic [3:0]  MODE_RESET  = 4'h0;
    localparam logic [4:0]  MAX_DATA_LEN = 5'h0A;
    localparam int          NUM_EP      = 3;

    typedef enum logic [1:0] {UEMR_TOK_SETUP, UEMR_TOK_IN, UEMR_TOK_OUT} uemr_tok_t;
    typedef enum logic [2:0] {UEMR_R_IGN, UEMR_R_ACK, UEMR_R_NAK, UEMR_R_STALL,
                              UEMR_R_CHECK, UEMR_R_TXCNT, UEMR_R_TX0} uemr_resp_t;
    typedef enum logic [2:0] {UEMR_HS_NONE, UEMR_HS_ACK, UEMR_HS_NAK, UEMR_HS_STALL,
                              UEMR_HS_DATA} uemr_hs_t;

    // Token from the link side, one-cycle start and end strobes
    typedef struct packed {
        logic       start;
        logic       data_start;
        logic       done;
        uemr_tok_t  tok;
        logic [1:0] ep;
        logic       addr_ok;
        logic [4:0] len;
        logic       crc_ok;
        logic       toggle;
    } uemr_txn_t;

    // Answer to the link side
    typedef struct packed {
        logic       valid;
        uemr_hs_t   hs;
        logic [3:0] data_len;
        logic [1:0] ep;
    } uemr_ans_t;
endpackage

// *** rtl/uemr_top.sv ***
// Endpoint mode responder: APB registers, token decision and mode updates
//
// Added by the designer: the APB slave port and the address map.
module uemr_top #(
    parameter int EP_SIZE = 8
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Transaction from the serial interface engine front end
    input  wire uemr_pkg::uemr_txn_t txn,
    // Answer and interrupt
    output uemr_pkg::uemr_ans_t     ans,
    output logic                    irq
);
    // The count field and the length field cannot serve larger endpoints
    if (EP_SIZE < 1 || EP_SIZE > 8) begin : g_bad_size
        $error("EP_SIZE must be 1..8");
    end

    logic [7:0] mode_reg  [uemr_pkg::NUM_EP];
    logic [7:0] count_reg [uemr_pkg::NUM_EP];
    logic [7:0] tokstat_reg;
    logic       lock_reg;
    logic       busy_reg;

    // Response decode per mode and token
    function automatic uemr_pkg::uemr_resp_t resp_of(input logic [3:0] m, input uemr_pkg::uemr_tok_t t);
        uemr_pkg::uemr_resp_t s;
        uemr_pkg::uemr_resp_t i;
        uemr_pkg::uemr_resp_t o;
        s = uemr_pkg::UEMR_R_IGN;
        i = uemr_pkg::UEMR_R_IGN;
        o = uemr_pkg::UEMR_R_IGN;
        case (m)
            4'h1: begin
                s = uemr_pkg::UEMR_R_ACK;
                i = uemr_pkg::UEMR_R_NAK;
                o = uemr_pkg::UEMR_R_NAK;
            end
            4'h2: begin
                s = uemr_pkg::UEMR_R_ACK;
                i = uemr_pkg::UEMR_R_STALL;
                o = uemr_pkg::UEMR_R_CHECK;
            end
            4'h3: begin
                s = uemr_pkg::UEMR_R_ACK;
                i = uemr_pkg::UEMR_R_STALL;
                o = uemr_pkg::UEMR_R_STALL;
            end
            4'h4: begin
                s = uemr_pkg::UEMR_R_ACK;
            end
            4'h5: begin
                o = uemr_pkg::UEMR_R_ACK;
            end
            4'h6: begin
                s = uemr_pkg::UEMR_R_ACK;
                i = uemr_pkg::UEMR_R_TX0;
                o = uemr_pkg::UEMR_R_STALL;
            end
            4'h7: begin
                i = uemr_pkg::UEMR_R_TXCNT;
            end
            4'h8: begin
                o = uemr_pkg::UEMR_R_NAK;
            end
            4'h9: begin
                o = uemr_pkg::UEMR_R_ACK;
            end
            4'hA: begin
                s = uemr_pkg::UEMR_R_ACK;
                i = uemr_pkg::UEMR_R_TX0;
                o = uemr_pkg::UEMR_R_NAK;
            end
            4'hB: begin
                s = uemr_pkg::UEMR_R_ACK;
                i = uemr_pkg::UEMR_R_NAK;
                o = uemr_pkg::UEMR_R_ACK;
            end
            4'hC: begin
                i = uemr_pkg::UEMR_R_NAK;
            end
            4'hD: begin
                i = uemr_pkg::UEMR_R_TXCNT;
            end
            4'hE: begin
                s = uemr_pkg::UEMR_R_ACK;
                i = uemr_pkg::UEMR_R_NAK;
                o = uemr_pkg::UEMR_R_CHECK;
            end
            4'hF: begin
                s = uemr_pkg::UEMR_R_ACK;
                i = uemr_pkg::UEMR_R_TXCNT;
                o = uemr_pkg::UEMR_R_CHECK;
            end
            default: begin
            end
        endcase
        case (t)
            uemr_pkg::UEMR_TOK_SETUP: resp_of = s;
            uemr_pkg::UEMR_TOK_IN:    resp_of = i;
            default:                  resp_of = o;
        endcase
    endfunction

    // Decision for the transaction now ending
    logic [3:0]           cur_mode;
    logic                 cur_stall;
    uemr_pkg::uemr_resp_t cur_resp;
    logic                 is_data_tok;
    logic                 too_long;
    logic                 data_ok;
    uemr_pkg::uemr_hs_t   hs_next;
    logic [3:0]           mode_next;
    logic                 mode_chg;
    logic                 fifo_bad;
    logic                 ep_ok;
    logic [1:0]           ep_idx;

    always_comb begin
        // Endpoint numbers beyond the implemented ones never index the arrays
        ep_ok       = int'(txn.ep) < uemr_pkg::NUM_EP;
        ep_idx      = ep_ok ? txn.ep : 2'd0;
        cur_mode    = mode_reg[ep_idx][3:0];
        cur_stall   = (txn.ep != 2'd0) && mode_reg[ep_idx][uemr_pkg::STALL_BIT];
        cur_resp    = resp_of(cur_mode, txn.tok);
        is_data_tok = txn.tok != uemr_pkg::UEMR_TOK_IN;
        too_long    = is_data_tok && (txn.len > uemr_pkg::MAX_DATA_LEN);
        data_ok     = !is_data_tok || (txn.crc_ok && ({1'b0, txn.len} < 6'(EP_SIZE + 2)));
        hs_next     = uemr_pkg::UEMR_HS_NONE;
        mode_next   = cur_mode;
        mode_chg    = 1'b0;
        fifo_bad    = ep_ok && is_data_tok && txn.addr_ok && !txn.crc_ok && cur_mode != uemr_pkg::MODE_RESET;
        if (ep_ok && txn.addr_ok && data_ok && !too_long) begin
            case (cur_resp)
                uemr_pkg::UEMR_R_ACK: begin
                    hs_next = cur_stall ? uemr_pkg::UEMR_HS_STALL : uemr_pkg::UEMR_HS_ACK;
                end
                uemr_pkg::UEMR_R_NAK:   hs_next = uemr_pkg::UEMR_HS_NAK;
                uemr_pkg::UEMR_R_STALL: hs_next = uemr_pkg::UEMR_HS_STALL;
                uemr_pkg::UEMR_R_CHECK: begin
                    hs_next = (txn.len == 5'd2 && txn.toggle) ? uemr_pkg::UEMR_HS_ACK
                                                            : uemr_pkg::UEMR_HS_STALL;
                end
                uemr_pkg::UEMR_R_TXCNT: begin
                    hs_next = cur_stall ? uemr_pkg::UEMR_HS_STALL : uemr_pkg::UEMR_HS_DATA;
                end
                uemr_pkg::UEMR_R_TX0:   hs_next = uemr_pkg::UEMR_HS_DATA;
                default:                hs_next = uemr_pkg::UEMR_HS_NONE;
            endcase
        end
        // Automatic mode changes after a successful exchange
        if (hs_next == uemr_pkg::UEMR_HS_ACK || hs_next == uemr_pkg::UEMR_HS_DATA) begin
            mode_chg = 1'b1;
            if (txn.tok == uemr_pkg::UEMR_TOK_SETUP) mode_next = 4'h1;
            else if (txn.tok == uemr_pkg::UEMR_TOK_OUT) begin
                if (cur_mode == 4'hB) mode_next = 4'h1;
                else if (cur_mode == 4'h9) mode_next = 4'h8;
                else if (cur_mode == 4'hF) mode_next = 4'hE;
            end else begin
                if (cur_mode == 4'hD) mode_next = 4'hC;
                else if (cur_mode == 4'hF) mode_next = 4'hE;
            end
        end
    end

    // APB decode
    logic       apb_acc;
    logic       apb_wr;
    logic       apb_rd;
    logic       addr_hit;
    logic [1:0] sel_ep;
    logic       sel_count;
    always_comb begin
        apb_acc   = psel && penable;
        apb_wr    = apb_acc && pwrite;
        apb_rd    = apb_acc && !pwrite;
        addr_hit  = (paddr <= uemr_pkg::REG_STATUS) && (paddr[1:0] == 2'b00);
        sel_ep    = 2'(paddr[4:3]);
        sel_count = paddr[2];
    end

    // Track end of transaction for the lock window
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
        end else if (txn.start) begin
            busy_reg <= 1'b1;
        end else if (txn.done) begin
            busy_reg <= 1'b0;
        end
    end

    // Control endpoint lock; a fresh ACK wins over an unlocking read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_reg <= 1'b0;
        end else if (txn.done && txn.ep == 2'd0 && hs_next == uemr_pkg::UEMR_HS_ACK) begin
            lock_reg <= 1'b1;
        end else if (apb_rd && addr_hit && sel_ep == 2'd0 && paddr != uemr_pkg::REG_STATUS && !busy_reg) begin
            lock_reg <= 1'b0;
        end
    end

    // Mode and count registers
    genvar g;
    generate
        for (g = 0; g < uemr_pkg::NUM_EP; g++) begin : g_ep
            logic wr_ok;
            assign wr_ok = apb_wr && addr_hit && sel_ep == 2'(g) && paddr != uemr_pkg::REG_STATUS
                           && !(g == 0 && lock_reg);
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mode_reg[g] <= {4'h0, uemr_pkg::MODE_RESET};
                end else if (txn.done && txn.ep == 2'(g) && mode_chg) begin
                    mode_reg[g] <= {mode_reg[g][7:4], mode_next};
                end else if (wr_ok && !sel_count) begin
                    mode_reg[g] <= pwdata[7:0];
                end
            end
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    count_reg[g] <= 8'h00;
                end else if (wr_ok && sel_count) begin
                    count_reg[g] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // Control endpoint token status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tokstat_reg <= 8'h00;
        end else if (txn.data_start && txn.ep == 2'd0 && txn.tok == uemr_pkg::UEMR_TOK_SETUP
                     && mode_reg[0][3:0] != uemr_pkg::MODE_RESET) begin
            tokstat_reg <= 8'h80;
        end else if (txn.done && txn.ep == 2'd0 && hs_next != uemr_pkg::UEMR_HS_NONE
                     && txn.tok != uemr_pkg::UEMR_TOK_SETUP) begin
            tokstat_reg[uemr_pkg::TOK_IN_BIT]    <= txn.tok == uemr_pkg::UEMR_TOK_IN;
            tokstat_reg[uemr_pkg::TOK_OUT_BIT]   <= txn.tok == uemr_pkg::UEMR_TOK_OUT;
            tokstat_reg[uemr_pkg::TOK_SETUP_BIT] <= 1'b0;
        end
    end

    // Answer to the link and interrupt pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ans <= '0;
            irq <= 1'b0;
        end else begin
            ans.valid    <= txn.done && hs_next != uemr_pkg::UEMR_HS_NONE;
            ans.hs       <= txn.done ? hs_next : uemr_pkg::UEMR_HS_NONE;
            ans.data_len <= (cur_resp == uemr_pkg::UEMR_R_TXCNT) ? count_reg[ep_idx][3:0] : 4'h0;
            ans.ep       <= txn.ep;
            irq          <= txn.done && (hs_next != uemr_pkg::UEMR_HS_NONE || fifo_bad
                            || (too_long && txn.addr_ok && cur_resp == uemr_pkg::UEMR_R_ACK));
        end
    end

    // APB read and response, zero wait states
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_hit;
            if (psel && !penable && !pwrite) begin
                if (!addr_hit) prdata <= 32'h0000_0000;
                else if (paddr == uemr_pkg::REG_STATUS) prdata <= {24'h00_0000, tokstat_reg};
                else if (sel_count) prdata <= {24'h00_0000, count_reg[sel_ep]};
                else prdata <= {24'h00_0000, mode_reg[sel_ep]};
            end
        end
    end
endmodule

// *** dv/uemr_assertions.sv ***
// Checker: port-level properties of the endpoint mode responder
module uemr_checker #(
    parameter int EP_SIZE = 8
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // APB handshake
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    // Link side
    input wire uemr_pkg::uemr_txn_t txn,
    input wire uemr_pkg::uemr_ans_t ans,
    input wire logic                irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic data_end;
    assign data_end = txn.done && txn.tok != uemr_pkg::UEMR_TOK_IN;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_ans_cause; ans.valid |-> $past(txn.done); endproperty
    a_ans_cause: assert property (p_ans_cause) else $error("answer without transaction end");
    property p_bad_crc; data_end && !txn.crc_ok |=> !ans.valid; endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("handshake on bad crc");
    property p_bad_addr; txn.done && !txn.addr_ok |=> !ans.valid; endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("handshake on foreign address");
    property p_too_long; data_end && txn.len >= 5'(EP_SIZE + 2) |=> !ans.valid; endproperty
    a_too_long: assert property (p_too_long) else $error("handshake on oversized packet");
    property p_ep_echo; ans.valid |-> ans.ep == $past(txn.ep); endproperty
    a_ep_echo: assert property (p_ep_echo) else $error("answer for wrong endpoint");
    property p_irq_ans; ans.valid |-> irq; endproperty
    a_irq_ans: assert property (p_irq_ans) else $error("no interrupt with answer");
    property p_irq_pulse; irq |=> !irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a pulse");
    property p_in_no_ack; txn.done && !data_end |=> !(ans.valid && ans.hs == uemr_pkg::UEMR_HS_ACK); endproperty
    a_in_no_ack: assert property (p_in_no_ack) else $error("ack sent to an in token");
    property p_pready; psel && !penable |=> pready; endproperty
    a_pready: assert property (p_pready) else $error("no ready in first access cycle");
endmodule

bind uemr_top uemr_checker #(.EP_SIZE(EP_SIZE)) u_checker (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready), .txn(txn), .ans(ans), .irq(irq)
);

// *** dv/uemr_host.sv ***
// Host model: issues token transactions and collects the answer
module uemr_host (
    // Clock
    input wire logic                 clk,
    // Link side
    output uemr_pkg::uemr_txn_t      txn,
    input  wire uemr_pkg::uemr_ans_t ans,
    input  wire logic                irq
);
    timeunit 1ns;
    timeprecision 1ps;
    initial txn = '0;
    task automatic send(input uemr_pkg::uemr_tok_t tok, input logic [1:0] ep, input logic [4:0] len,
                        input logic crc, input logic tog, input logic aok,
                        output uemr_pkg::uemr_ans_t got, output logic got_irq);
        @(posedge clk);
        txn <= '{1'b1, 1'b0, 1'b0, tok, ep, aok, len, crc, tog};
        @(posedge clk);
        txn <= '{1'b0, 1'b1, 1'b0, tok, ep, aok, len, crc, tog};
        @(posedge clk);
        txn <= '{1'b0, 1'b0, 1'b1, tok, ep, aok, len, crc, tog};
        @(posedge clk);
        // Released fields no longer carry the old values
        txn <= '{1'b0, 1'b0, 1'b0, uemr_pkg::uemr_tok_t'(~tok), ~ep, ~aok, ~len, ~crc, ~tog};
        got = '0;
        got_irq = 1'b0;
        repeat (3) begin
            #1;
            if (ans.valid && !got.valid) got = ans;
            got_irq = got_irq | irq;
            @(posedge clk);
        end
    endtask
endmodule

// *** dv/usb_endpoint_mode_responder_tb.sv ***
// Testbench: APB register access and token scenarios for the responder
module usb_endpoint_mode_responder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SU = 0, TI = 1, TO = 2, HN = 0, HA = 1, HK = 2, HS = 3, HD = 4;
    localparam logic [11:0] M0 = uemr_pkg::REG_MODE0, C0 = uemr_pkg::REG_COUNT0, ST = uemr_pkg::REG_STATUS;
    localparam logic [11:0] M1 = uemr_pkg::REG_MODE1, C1 = uemr_pkg::REG_COUNT1;
    logic                clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]         paddr = '0;
    logic [31:0]         pwdata = '0, prdata, rd;
    logic                pready, pslverr, irq, gi, err;
    uemr_pkg::uemr_txn_t txn;
    uemr_pkg::uemr_ans_t ans, ga;
    int                  fail_count = 0, total_checks = 0;
    always #10 clk = ~clk;
    uemr_top #(.EP_SIZE(8)) DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txn(txn),
        .ans(ans), .irq(irq));
    uemr_host u_host (.clk(clk), .txn(txn), .ans(ans), .irq(irq));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so that a following call never re-raises psel in this time step
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check("register", exp, rd & 32'h0000_00FF);
    endtask
    task automatic xact(input int t, input logic [1:0] ep, input logic [4:0] len, input logic tog,
                        input logic [1:0] ok, input int hs, input logic [3:0] dl, input logic ei);
        u_host.send(uemr_pkg::uemr_tok_t'(t), ep, len, ok[0], tog, ok[1], ga, gi);
        check("handshake", 32'(hs), 32'(ga.hs));
        if (hs == HD) check("data length", 32'(dl), 32'(ga.data_len));
        check("interrupt", 32'(ei), 32'(gi));
    endtask
    initial begin
        #100_000;
        fail_count++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        reg_rd(M0, 32'h0000_0000);
        xact(SU, 2'd0, 5'd8, 1'b0, 2'b11, HN, 4'h0, 1'b0);
        apb(1'b1, M0, 32'h0000_000F);
        xact(SU, 2'd0, 5'd8, 1'b0, 2'b11, HA, 4'h0, 1'b1);
        reg_rd(ST, 32'h0000_0080);
        apb(1'b1, M0, 32'h0000_0003);
        reg_rd(M0, 32'h0000_0001);
        xact(TI, 2'd0, 5'd0, 1'b0, 2'b11, HK, 4'h0, 1'b1);
        reg_rd(ST, 32'h0000_0040);
        xact(TO, 2'd0, 5'd2, 1'b1, 2'b11, HK, 4'h0, 1'b1);
        xact(TO, 2'd0, 5'd20, 1'b1, 2'b11, HN, 4'h0, 1'b0);
        apb(1'b1, C0, 32'h0000_0005);
        apb(1'b1, M0, 32'h0000_000F);
        reg_rd(M0, 32'h0000_000F);
        xact(TI, 2'd0, 5'd0, 1'b0, 2'b11, HD, 4'h5, 1'b1);
        apb(1'b1, M0, 32'h0000_000F);
        xact(TO, 2'd0, 5'd2, 1'b0, 2'b11, HS, 4'h0, 1'b1);
        xact(TO, 2'd0, 5'd2, 1'b1, 2'b11, HA, 4'h0, 1'b1);
        reg_rd(M0, 32'h0000_000E);
        apb(1'b1, M0, 32'h0000_000B);
        xact(TO, 2'd0, 5'd2, 1'b1, 2'b10, HN, 4'h0, 1'b1);
        xact(TO, 2'd0, 5'd2, 1'b1, 2'b11, HA, 4'h0, 1'b1);
        reg_rd(M0, 32'h0000_0001);
        apb(1'b1, M0, 32'h0000_0006);
        xact(TI, 2'd0, 5'd0, 1'b0, 2'b11, HD, 4'h0, 1'b1);
        xact(TI, 2'd0, 5'd0, 1'b0, 2'b01, HN, 4'h0, 1'b0);
        apb(1'b1, M1, 32'h0000_0009);
        xact(TI, 2'd1, 5'd0, 1'b0, 2'b11, HN, 4'h0, 1'b0);
        xact(TO, 2'd1, 5'd4, 1'b0, 2'b11, HA, 4'h0, 1'b1);
        reg_rd(M1, 32'h0000_0008);
        apb(1'b1, M1, 32'h0000_0089);
        xact(TO, 2'd1, 5'd4, 1'b0, 2'b11, HS, 4'h0, 1'b1);
        apb(1'b1, C1, 32'h0000_0003);
        apb(1'b1, M1, 32'h0000_000D);
        xact(TI, 2'd1, 5'd0, 1'b0, 2'b11, HD, 4'h3, 1'b1);
        apb(1'b1, M1, 32'h0000_008D);
        xact(TI, 2'd1, 5'd0, 1'b0, 2'b11, HS, 4'h0, 1'b1);
        apb(1'b0, 12'h100, 32'h0000_0000);
        check("slave error", 32'h0000_0001, 32'(err));
        print_verdict;
    end
endmodule
